// ===== design/mbhp_defines.vh
// Purpose: shared constants for the muxed bus host port
// Assumes: 8-bit multiplexed address/data bus, one 250 MHz core clock
// Notes:   timing figures are kept in their printed unit and converted to cycles here
`ifndef MBHP_DEFINES_VH
`define MBHP_DEFINES_VH

// bus width and address field layout
`define MBHP_BUS_W          8
`define MBHP_IDX_W          4
`define MBHP_IDX_MSB        4
`define MBHP_IDX_LSB        1
`define MBHP_CH_BIT_RIGHT   0
`define MBHP_CH_BIT_LEFT    5

// positions of the pin group inside the synchroniser vector
`define MBHP_SY_AS          0
`define MBHP_SY_DS          1
`define MBHP_SY_CSL         2
`define MBHP_SY_CSH         3
`define MBHP_SY_IACK        4
`define MBHP_SY_RW          5
`define MBHP_SY_IEI         6
`define MBHP_SY_BUS_LSB     7
`define MBHP_SY_BUS_MSB     14
`define MBHP_SY_W           15

// recovery gap between two accesses to this device
`define MBHP_CLK_PERIOD_NS  4
`define MBHP_RECOV_CYCLES   6
`define MBHP_RECOV_NS       200
`define MBHP_RECOV_TOTAL    (`MBHP_RECOV_CYCLES + ((`MBHP_RECOV_NS + `MBHP_CLK_PERIOD_NS - 1) / `MBHP_CLK_PERIOD_NS))
`define MBHP_RECOV_CNT_W    7

// cycle kinds reported to the core
`define MBHP_KIND_NONE      2'h0
`define MBHP_KIND_READ      2'h1
`define MBHP_KIND_WRITE     2'h2
`define MBHP_KIND_ACK       2'h3

// reset values
`define MBHP_BYTE_ZERO      8'h00
`define MBHP_PIN_IDLE_CTL   7'h3F

`endif

// ===== design/mbhp_sync.v
// Purpose: two flip-flop synchroniser for a group of asynchronous pins
// Assumes: each bit is an independent level; grouped bits may resolve one cycle apart
// Notes:   stage one feeds stage two only
`timescale 1ns/1ns
module mbhp_sync #(
    parameter WIDTH    = 1,
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
    input  wire             clk,
    input  wire             rstn,
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_reg;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_reg <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule // mbhp_sync

// ===== design/mbhp_port.v
// Purpose: host-side port of a dual-channel serial controller on a muxed address/data bus
// Assumes: strobes and bus pins are asynchronous to clk; the core answers read data combinationally
// Notes:   pin reactions lag the pins by the two synchroniser stages plus one output stage; bus drive onset lags by one stage more
//          the recovery gap is only flagged, never enforced; the host owns the spacing
//
// Overview of operation
// R1 - internal bus pulses come from address and data strobes, timed by clk
// R2 - strobes are asynchronous, so they pass synchronisers before use
// R3 - host leaves 6 clocks plus 200 ns between accesses to this device
// R4 - the gap only applies between two accesses both aimed at this device
// R5 - address, low chip select and acknowledge level latch at address strobe rise
// R6 - a read has read/write select high during the data strobe
// R7 - a read only happens with the high chip select high as well
// R8 - a selected read drives the bus only while the data strobe is low
// R9 - a write has read/write select low during the data strobe
// R10 - a write only takes effect with the high chip select high
// R11 - write data is taken from the bus during the data strobe low phase; the code takes the bus sample seen as the strobe rises
// R12 - latched acknowledge low makes an acknowledge cycle, ignoring address and low select
// R13 - an acknowledge cycle ignores read/write select and high chip select
// R14 - daisy chains settle between address strobe rise and data strobe fall
// R15 - acknowledge is ours only with interrupt pending and chain enable high at strobe fall
// R16 - an owned acknowledge drives the vector while data strobe is low, if enabled
// R17 - an accepted acknowledge sets the in-service latch of the serviced source
// R18 - shift-right addressing takes the channel from bit 0, ignoring bit 5
// R19 - shift-left addressing takes the channel from bit 5, ignoring bit 0
// R20 - top two bus bits are never address; register number is bits 4 to 1
// R21 - two-stage synchronise both strobes, then make one-cycle latch and strobe pulses
`timescale 1ns/1ns
`include "mbhp_defines.vh"
module mbhp_port #(
    parameter BUS_W = `MBHP_BUS_W
) (
    input  wire             clk,
    input  wire             rstn,
    // processor pins
    input  wire             address_strobe_n,
    input  wire             data_strobe_n,
    input  wire             chip_select_low,
    input  wire             chip_select_high,
    input  wire             irq_acknowledge_n,
    input  wire             read_write,
    input  wire [BUS_W-1:0] muxed_addr_data_bus_in,
    output reg  [BUS_W-1:0] muxed_addr_data_bus_out,
    output reg              muxed_addr_data_bus_oe,
    input  wire             chain_enable_in,
    output reg              chain_enable_out,
    // core side
    input  wire             shift_left_mode,
    input  wire             irq_pending,
    input  wire             vector_respond_en,
    input  wire [BUS_W-1:0] vector_in,
    input  wire [BUS_W-1:0] read_data_in,
    output reg              reg_channel,
    output reg  [`MBHP_IDX_W-1:0] reg_index,
    output reg  [1:0]       cycle_kind,
    output reg              read_pulse,
    output reg              write_pulse,
    output reg  [BUS_W-1:0] write_data,
    output reg              in_service_set,
    output reg              ack_ignored,
    output reg              recovery_violation
);
    localparam ST_IDLE   = 2'h0;
    localparam ST_ARMED  = 2'h1;
    localparam ST_ACTIVE = 2'h2;

    localparam integer                  RECOV_TOTAL = `MBHP_RECOV_TOTAL;
    localparam [`MBHP_RECOV_CNT_W-1:0] RECOV_LAST  = RECOV_TOTAL[`MBHP_RECOV_CNT_W-1:0];
    localparam [`MBHP_RECOV_CNT_W-1:0] RECOV_FIRST = {{(`MBHP_RECOV_CNT_W-1){1'b0}}, 1'b1};

    // pin reset levels: strobes, both selects, acknowledge and read/write idle high
    // low select idling high keeps a half-filled synchroniser from looking selected
    localparam [`MBHP_SY_W-1:0] PIN_IDLE = {{BUS_W{1'b0}}, `MBHP_PIN_IDLE_CTL};

    wire [`MBHP_SY_W-1:0] pin_raw;
    wire [`MBHP_SY_W-1:0] pin_sync;

    reg               as_prev_reg;
    reg               ds_prev_reg;
    reg  [1:0]        state_reg;
    reg  [1:0]        state_next;
    reg               csl_lat_reg;
    reg               iack_lat_reg;
    reg               drive_vec_reg;
    reg               recov_busy_reg;
    reg  [`MBHP_RECOV_CNT_W-1:0] recov_cnt_reg;

    wire              as_s;
    wire              ds_s;
    wire              csh_s;
    wire              rw_s;
    wire              iei_s;
    wire [BUS_W-1:0]  bus_s;
    wire              as_rise;
    wire              ds_fall;
    wire              ds_rise;
    wire              is_ack;
    wire              selected;
    wire              rd_ok;
    wire              wr_ok;
    wire              ack_own;
    wire              ours;

    // channel select depends on the addressing mode
    function chan_of;
        input [BUS_W-1:0] addr;
        input             left;
        begin
            if (left)
                chan_of = addr[`MBHP_CH_BIT_LEFT];   // [R19]
            else
                chan_of = addr[`MBHP_CH_BIT_RIGHT];  // [R18]
        end
    endfunction

    assign pin_raw = {muxed_addr_data_bus_in, chain_enable_in, read_write, irq_acknowledge_n,
                      chip_select_high, chip_select_low, data_strobe_n, address_strobe_n};

    // every pin, strobes included, gets two stages before anything looks at it
    mbhp_sync #(
        .WIDTH     (`MBHP_SY_W),
        .RESET_VAL (PIN_IDLE)
    ) u_pin_sync (
        .clk       (clk),
        .rstn      (rstn),
        .async_in  (pin_raw),
        .sync_out  (pin_sync)
    ); // [R2] [R21]

    assign as_s  = pin_sync[`MBHP_SY_AS];
    assign ds_s  = pin_sync[`MBHP_SY_DS];
    assign csh_s = pin_sync[`MBHP_SY_CSH];
    assign rw_s  = pin_sync[`MBHP_SY_RW];
    assign iei_s = pin_sync[`MBHP_SY_IEI];
    assign bus_s = pin_sync[`MBHP_SY_BUS_MSB:`MBHP_SY_BUS_LSB];

    // one-cycle pulses from the synchronised strobes
    assign as_rise = as_s & ~as_prev_reg;   // [R1] [R21]
    assign ds_fall = ~ds_s & ds_prev_reg;   // [R1] [R21]
    assign ds_rise = ds_s & ~ds_prev_reg;   // [R1] [R21]

    // acknowledge overrides address decode and both chip selects
    // the chain input goes through the synchroniser, so the settle time must cover it
    assign is_ack   = ~iack_lat_reg;                         // [R12] [R13]
    assign selected = ~is_ack & ~csl_lat_reg;                // [R12]
    assign rd_ok    = selected & csh_s & rw_s;               // [R6] [R7]
    assign wr_ok    = selected & csh_s & ~rw_s;              // [R9] [R10]
    assign ack_own  = is_ack & irq_pending & iei_s;          // [R14] [R15]
    assign ours     = rd_ok | wr_ok | ack_own;

    // a data strobe with no address strobe rise before it never leaves idle
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (as_rise)
                    state_next = ST_ARMED;
            end
            ST_ARMED: begin
                if (as_rise)
                    state_next = ST_ARMED;
                else if (ds_fall)
                    state_next = ST_ACTIVE;
            end
            ST_ACTIVE: begin
                if (ds_rise)
                    state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            as_prev_reg <= 1'b1;
            ds_prev_reg <= 1'b1;
            state_reg   <= ST_IDLE;
        end else begin
            as_prev_reg <= as_s;
            ds_prev_reg <= ds_s;
            state_reg   <= state_next;
        end
    end

    // address phase: address, low select and acknowledge level are frozen at the strobe rise
    // on an acknowledge the latched address and low select are simply never looked at
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            csl_lat_reg  <= 1'b1;
            iack_lat_reg <= 1'b1;
            reg_channel  <= 1'b0;
            reg_index    <= {`MBHP_IDX_W{1'b0}};
        end else if (as_rise) begin
            csl_lat_reg  <= pin_sync[`MBHP_SY_CSL];                   // [R5]
            iack_lat_reg <= pin_sync[`MBHP_SY_IACK];                  // [R5]
            reg_channel  <= chan_of(bus_s, shift_left_mode);          // [R5] [R18] [R19]
            reg_index    <= bus_s[`MBHP_IDX_MSB:`MBHP_IDX_LSB];       // [R20]
        end
    end

    // data phase: decide the cycle kind when the data strobe falls
    // a foreign acknowledge only reports itself; the bus stays released
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cycle_kind     <= `MBHP_KIND_NONE;
            read_pulse     <= 1'b0;
            in_service_set <= 1'b0;
            ack_ignored    <= 1'b0;
            drive_vec_reg  <= 1'b0;
        end else begin
            read_pulse     <= 1'b0;
            in_service_set <= 1'b0;
            ack_ignored    <= 1'b0;
            if (state_reg == ST_ARMED && ds_fall) begin
                if (is_ack) begin
                    cycle_kind     <= ack_own ? `MBHP_KIND_ACK : `MBHP_KIND_NONE;
                    in_service_set <= ack_own;                           // [R17]
                    ack_ignored    <= ~ack_own;                          // [R15]
                    drive_vec_reg  <= ack_own & vector_respond_en;       // [R16]
                end else if (rd_ok) begin
                    cycle_kind     <= `MBHP_KIND_READ;
                    read_pulse     <= 1'b1;                              // [R7]
                    drive_vec_reg  <= 1'b0;
                end else if (wr_ok) begin
                    cycle_kind     <= `MBHP_KIND_WRITE;
                    drive_vec_reg  <= 1'b0;
                end else begin
                    cycle_kind     <= `MBHP_KIND_NONE;
                    drive_vec_reg  <= 1'b0;
                end
            end else if (ds_rise) begin
                drive_vec_reg <= 1'b0;
            end
        end
    end

    // bus drivers follow the synchronised data strobe low phase
    // the output byte is zeroed while released so no stale value lingers on the driver
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            muxed_addr_data_bus_oe  <= 1'b0;
            muxed_addr_data_bus_out <= `MBHP_BYTE_ZERO;
        end else begin
            if (state_next == ST_ACTIVE && ~ds_s &&
                (cycle_kind == `MBHP_KIND_READ || drive_vec_reg) && state_reg == ST_ACTIVE) begin
                muxed_addr_data_bus_oe  <= 1'b1;                         // [R8] [R16]
                muxed_addr_data_bus_out <= drive_vec_reg ? vector_in : read_data_in;
            end else begin
                muxed_addr_data_bus_oe  <= 1'b0;                         // [R8]
                muxed_addr_data_bus_out <= `MBHP_BYTE_ZERO;
            end
        end
    end

    // write data is the bus sample taken together with the first high strobe sample
    // landing at the rise means a cut strobe still writes, using the bus sampled as the strobe rose
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            write_pulse <= 1'b0;
            write_data  <= `MBHP_BYTE_ZERO;
        end else begin
            write_pulse <= 1'b0;
            if (state_reg == ST_ACTIVE && ds_rise && cycle_kind == `MBHP_KIND_WRITE) begin
                write_pulse <= 1'b1;                                     // [R10] [R11]
                write_data  <= bus_s;                                    // [R11]
            end
        end
    end

    // daisy chain: pass enable down only when nothing here wants service
    // the enable lags its input by the synchroniser and one output stage
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            chain_enable_out <= 1'b0;
        end else begin
            chain_enable_out <= iei_s & ~irq_pending;                    // [R14]
        end
    end

    // recovery watch: only accesses aimed at this device start or check the gap
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            recov_busy_reg     <= 1'b0;
            recov_cnt_reg      <= {`MBHP_RECOV_CNT_W{1'b0}};
            recovery_violation <= 1'b0;
        end else begin
            recovery_violation <= 1'b0;
            if (state_reg == ST_ACTIVE && ds_rise && cycle_kind != `MBHP_KIND_NONE) begin
                // starting at one lets a gap of exactly the minimum pass unflagged
                recov_busy_reg <= 1'b1;                                  // [R3] [R4]
                recov_cnt_reg  <= RECOV_FIRST;
            end else if (recov_busy_reg) begin
                if (recov_cnt_reg == RECOV_LAST - 1'b1)
                    recov_busy_reg <= 1'b0;
                recov_cnt_reg <= recov_cnt_reg + 1'b1;
            end
            if (state_reg == ST_ARMED && ds_fall && ours && recov_busy_reg)
                recovery_violation <= 1'b1;                              // [R3] [R4]
        end
    end
endmodule // mbhp_port

// ===== dv/mbhp_checker.sv
// Purpose: pin-level assertions for the muxed bus host port
// Assumes: two sync stages plus one output register between pins and outputs
// Notes:   host holds bus, selects and core inputs steady around strobe edges
`timescale 1ns/1ns
`include "mbhp_defines.vh"
module mbhp_checker #(
    parameter BUS_W = 8
) (
    input wire                   clk,
    input wire                   rstn,
    input wire                   data_strobe_n,
    input wire                   shift_left_mode,
    input wire                   irq_pending,
    input wire                   vector_respond_en,
    input wire [BUS_W-1:0]       read_data_in,
    input wire [BUS_W-1:0]       muxed_addr_data_bus_in,
    input wire [BUS_W-1:0]       muxed_addr_data_bus_out,
    input wire                   muxed_addr_data_bus_oe,
    input wire                   chain_enable_out,
    input wire                   reg_channel,
    input wire [`MBHP_IDX_W-1:0] reg_index,
    input wire [1:0]             cycle_kind,
    input wire                   read_pulse,
    input wire                   write_pulse,
    input wire [BUS_W-1:0]       write_data,
    input wire                   in_service_set,
    input wire                   ack_ignored
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    wire             oe = muxed_addr_data_bus_oe;
    wire [BUS_W-1:0] bi = muxed_addr_data_bus_in;
    wire             any_pulse = read_pulse | write_pulse | in_service_set | ack_ignored;
    sequence s_read_drive; oe && muxed_addr_data_bus_out == $past(read_data_in); endsequence
    sequence s_bus_quiet; !oe [*4]; endsequence
    property p_oe_ds; oe |-> !$past(data_strobe_n, 3); endproperty
    property p_oe_cause;
        $rose(oe) |-> cycle_kind == `MBHP_KIND_READ || cycle_kind == `MBHP_KIND_ACK && vector_respond_en;
    endproperty
    property p_read_drive; read_pulse |=> s_read_drive; endproperty
    property p_pulse_one; any_pulse |=> !any_pulse; endproperty
    property p_isr_owned; in_service_set |-> cycle_kind == `MBHP_KIND_ACK && $past(irq_pending); endproperty
    property p_ign_quiet; ack_ignored |=> s_bus_quiet; endproperty
    property p_write_take; write_pulse |-> cycle_kind == `MBHP_KIND_WRITE && write_data == $past(bi, 3); endproperty
    property p_chain_out; $past(irq_pending) |-> !chain_enable_out; endproperty
    property p_addr_decode;
        $changed(reg_index) || $changed(reg_channel) |-> reg_index == $past(bi[4:1], 3)
            && reg_channel == (shift_left_mode ? $past(bi[5], 3) : $past(bi[0], 3));
    endproperty
    a_oe_ds: assert property (p_oe_ds) else $error("bus driven with strobe high");
    a_oe_cause: assert property (p_oe_cause) else $error("bus driven without cause");
    a_read_drive: assert property (p_read_drive) else $error("read data not driven");
    a_pulse_one: assert property (p_pulse_one) else $error("pulse longer than one cycle");
    a_isr_owned: assert property (p_isr_owned) else $error("in-service set when not owned");
    a_ign_quiet: assert property (p_ign_quiet) else $error("bus driven on foreign acknowledge");
    a_write_take: assert property (p_write_take) else $error("write data wrong");
    a_chain_out: assert property (p_chain_out) else $error("chain passed while pending");
    a_addr_decode: assert property (p_addr_decode) else $error("address decode wrong");
endmodule // mbhp_checker

bind mbhp_port mbhp_checker #(.BUS_W(BUS_W)) u_chk (.clk, .rstn, .data_strobe_n, .shift_left_mode, .irq_pending,
    .vector_respond_en, .read_data_in, .muxed_addr_data_bus_in, .muxed_addr_data_bus_out, .muxed_addr_data_bus_oe,
    .chain_enable_out, .reg_channel, .reg_index, .cycle_kind, .read_pulse, .write_pulse, .write_data,
    .in_service_set, .ack_ignored);

// ===== dv/mbhp_host.sv
// Purpose: processor model that runs bus cycles on the muxed bus pins
// Assumes: pins change only just after a rising clock edge
// Notes:   a released bus shows a moving pattern, so stale values never pass
`timescale 1ns/1ns
module mbhp_host (
    input  wire       clk,
    input  wire [7:0] dut_bus,
    input  wire       dut_oe,
    output reg        as_n = 1'b1,
    output reg        ds_n = 1'b1,
    output reg        csl_n = 1'b1,
    output reg        csh = 1'b0,
    output reg        iack_n = 1'b1,
    output reg        rw = 1'b1,
    output wire [7:0] bus
);
    reg       drv = 1'b0;
    reg [7:0] dq = 8'h00;
    reg [7:0] pat = 8'h00;
    assign bus = dut_oe ? dut_bus : drv ? dq : pat;
    always @(posedge clk) begin
        pat <= {pat[6:0], ~pat[7]};
    end
    // k: 1 read, 2 write, 3 acknowledge; w spaces the strobes, gap is idle time after
    task xfer(input [1:0] k, input [7:0] a, d, input sl, sh, input integer w, gap, output [7:0] rd);
        @(posedge clk);
        dq <= a;
        drv <= 1'b1;
        csl_n <= ~sl;
        iack_n <= k != 2'h3;
        as_n <= 1'b0;
        repeat (4) @(posedge clk);
        as_n <= 1'b1;
        repeat (13) @(posedge clk);
        dq <= d;
        drv <= k == 2'h2;
        rw <= k == 2'h1;
        csh <= sh;
        repeat (w) @(posedge clk);
        ds_n <= 1'b0;
        repeat (2 * w) @(posedge clk);
        rd = bus;
        ds_n <= 1'b1;
        repeat (8) @(posedge clk);
        drv <= 1'b0;
        csl_n <= 1'b1;
        repeat (gap) @(posedge clk);
    endtask
endmodule // mbhp_host

// ===== dv/mbhp_port_test.sv
// Purpose: self-checking bench for the muxed bus host port
// Assumes: the processor model drives every bus pin
// Notes:   table rows cover ordinary cycles; recovery gap cases follow by hand
`timescale 1ns/1ns
`include "mbhp_defines.vh"
module mbhp_port_test;
    // m = {select low, select high, shift left, pending, vector enable, chain enable}
    // ea = {channel, index}; ev = {read, write, in service, ignored, bus driven}
    typedef struct packed {
        logic [1:0] k;
        logic [7:0] a;
        logic [7:0] d;
        logic [5:0] m;
        logic [1:0] ek;
        logic [4:0] ea;
        logic [4:0] ev;
    } mbhp_row_t;
    reg        clk = 1'b0;
    reg        rstn = 1'b0;
    reg  [5:0] m = 6'h00;
    reg  [7:0] cd = 8'h00;
    reg  [7:0] rd;
    wire       as_n, ds_n, csl_n, csh, iack_n, rw, oe, chan, rdp, wrp, isr, ign, rv, ceo;
    wire [7:0] bus, bo, wd;
    wire [3:0] idx;
    wire [1:0] kind;
    mbhp_row_t rows [0:9];
    mbhp_row_t r;
    integer    n_errors = 0, checks = 0, i, j;
    integer    cnt [0:5] = '{0, 0, 0, 0, 0, 0};
    integer    base [0:5];
    mbhp_host u_host (.clk(clk), .dut_bus(bo), .dut_oe(oe), .as_n(as_n), .ds_n(ds_n), .csl_n(csl_n),
        .csh(csh), .iack_n(iack_n), .rw(rw), .bus(bus));
    mbhp_port u_dut (.clk(clk), .rstn(rstn), .address_strobe_n(as_n), .data_strobe_n(ds_n),
        .chip_select_low(csl_n), .chip_select_high(csh), .irq_acknowledge_n(iack_n), .read_write(rw),
        .muxed_addr_data_bus_in(bus), .muxed_addr_data_bus_out(bo), .muxed_addr_data_bus_oe(oe),
        .chain_enable_in(m[0]), .chain_enable_out(ceo), .shift_left_mode(m[3]), .irq_pending(m[2]),
        .vector_respond_en(m[1]), .vector_in(cd), .read_data_in(cd), .reg_channel(chan), .reg_index(idx),
        .cycle_kind(kind), .read_pulse(rdp), .write_pulse(wrp), .write_data(wd), .in_service_set(isr),
        .ack_ignored(ign), .recovery_violation(rv));
    always @(posedge clk) begin
        cnt[0] <= cnt[0] + rdp;
        cnt[1] <= cnt[1] + wrp;
        cnt[2] <= cnt[2] + isr;
        cnt[3] <= cnt[3] + ign;
        cnt[4] <= cnt[4] + oe;
        cnt[5] <= cnt[5] + rv;
    end
    task chk_val(input [7:0] got, exp);
        checks = checks + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task chk_flag(input got, exp);
        chk_val({7'h00, got}, {7'h00, exp});
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        forever #2 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_errors = n_errors + 1;
        test_done;
    end
    initial begin
        rows[0] = {2'h1, 8'hE6, 8'h3C, 6'h31, 2'h1, 5'h03, 5'h11};
        rows[1] = {2'h1, 8'h9B, 8'hC5, 6'h31, 2'h1, 5'h1D, 5'h11};
        rows[2] = {2'h2, 8'hA0, 8'h5A, 6'h39, 2'h2, 5'h10, 5'h08};
        rows[3] = {2'h2, 8'h41, 8'hA7, 6'h39, 2'h2, 5'h00, 5'h08};
        rows[4] = {2'h1, 8'h02, 8'h81, 6'h21, 2'h0, 5'h01, 5'h00};
        rows[5] = {2'h2, 8'h04, 8'h99, 6'h11, 2'h0, 5'h02, 5'h00};
        rows[6] = {2'h3, 8'hFF, 8'h6E, 6'h37, 2'h3, 5'h00, 5'h05};
        rows[7] = {2'h3, 8'hFF, 8'h6E, 6'h05, 2'h3, 5'h00, 5'h04};
        rows[8] = {2'h3, 8'hFF, 8'h6E, 6'h01, 2'h0, 5'h00, 5'h02};
        rows[9] = {2'h3, 8'hFF, 8'h6E, 6'h06, 2'h0, 5'h00, 5'h02};
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        chk_flag(oe, 1'b0);
        chk_val({6'h00, kind}, 8'h00);
        $display("reset test done");
        for (i = 0; i < 10; i = i + 1) begin
            r = rows[i];
            m <= r.m;
            cd <= r.d;
            base = cnt;
            u_host.xfer(r.k, r.a, r.d, r.m[5], r.m[4], 51, `MBHP_RECOV_TOTAL, rd);
            for (j = 0; j < 5; j = j + 1) begin
                chk_flag(cnt[j] != base[j], r.ev[4 - j]);
            end
            if (!r.ev[1]) begin
                chk_val({6'h00, kind}, {6'h00, r.ek});
            end
            if (r.ev[0]) begin
                chk_val(rd, r.d);
            end
            if (r.ev[3]) begin
                chk_val(wd, r.d);
            end
            if (r.k != 2'h3 && r.ek != 2'h0) begin
                chk_val({3'h0, chan, idx}, {3'h0, r.ea});
            end
            chk_flag(ceo, r.m[0] & ~r.m[2]);
            $display("row %0d done", i);
        end
        base = cnt;
        u_host.xfer(2'h2, 8'h02, 8'h11, 1'b1, 1'b1, 4, 60, rd);
        u_host.xfer(2'h2, 8'h02, 8'h22, 1'b0, 1'b1, 4, 0, rd);
        u_host.xfer(2'h2, 8'h02, 8'h33, 1'b1, 1'b1, 4, 26, rd);
        u_host.xfer(2'h2, 8'h02, 8'h44, 1'b1, 1'b1, 4, 25, rd);
        chk_flag(cnt[5] != base[5], 1'b0);
        u_host.xfer(2'h2, 8'h02, 8'h55, 1'b1, 1'b1, 4, 60, rd);
        chk_flag(cnt[5] != base[5], 1'b1);
        chk_val(wd, 8'h55);
        $display("recovery test done");
        test_done;
    end
endmodule // mbhp_port_test
